// ---- rtl/loop_ctrl_pkg.sv ----
// ============================================================
// package for the closed loop controller with loop alarm
// ============================================================
// holds register indices, field positions, reset values and timing
// assumes a single 100 MHz clock and a plain strobe register port
package loop_ctrl_pkg;

  // ==========================================================
  // register indices (word addresses on the plain port)
  // ==========================================================
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam logic [4:0] IDX_MODE = 5'h00;
  localparam logic [4:0] IDX_GAIN = 5'h01;
  localparam logic [4:0] IDX_ITIME = 5'h02;
  localparam logic [4:0] IDX_DTIME = 5'h03;
  localparam logic [4:0] IDX_FILT = 5'h04;
  localparam logic [4:0] IDX_AWB = 5'h05;
  localparam logic [4:0] IDX_ALM_TYPE = 5'h06;
  localparam logic [4:0] IDX_ALM_UP = 5'h07;
  localparam logic [4:0] IDX_ALM_LO = 5'h08;
  localparam logic [4:0] IDX_OUT_UP = 5'h09;
  localparam logic [4:0] IDX_OUT_LO = 5'h0a;
  localparam logic [4:0] IDX_DOUT_FUNC = 5'h0b;
  localparam logic [4:0] IDX_CTRL = 5'h0c;
  localparam logic [4:0] IDX_STATUS = 5'h0d;
  localparam logic [4:0] IDX_MV = 5'h0e;
  localparam logic [4:0] IDX_FB_FILT = 5'h0f;

  // ==========================================================
  // field positions and codes
  // ==========================================================
  localparam int ALM_HOLD_BIT = 0;
  localparam int ALM_LATCH_BIT = 1;
  localparam int ALM_DEV_BIT = 2;
  localparam int CTRL_CLR_BIT = 0;
  localparam int ST_ALARM_BIT = 0;
  localparam int ST_ARMED_BIT = 1;
  localparam int ST_FREEZE_BIT = 2;
  localparam int ST_ACTIVE_BIT = 3;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_NORMAL = 2'h1;
  localparam logic [1:0] MODE_INVERSE = 2'h2;
  localparam logic [1:0] MODE_DANCER = 2'h3;
  localparam logic [15:0] CLAMP_USE_LIMITER = 16'h03e7; // 999
  localparam logic [15:0] DOUT_FUNC_ALARM = 16'h002a; // 42

  // ==========================================================
  // reset values and scaling (values in 0.01 % unless noted)
  // ==========================================================
  localparam logic [15:0] RST_GAIN = 16'h0064; // 0.100
  localparam logic [15:0] RST_OUT_UP = 16'h03e7;
  localparam logic [15:0] RST_OUT_LO = 16'h03e7;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam int GAIN_DIV = 1000; // gain unit 0.001
  localparam int PCT_TO_CENTI = 100; // clamp unit 1 %
  localparam int AWB_TO_CENTI = 10; // band unit 0.1 %
  localparam int FRAC_BITS = 16;

  // ==========================================================
  // timing
  // ==========================================================
  localparam int CLK_PERIOD_NS = 10;
  localparam int CTRL_PERIOD_NS = 1000000; // 1 ms control period
  localparam int CTRL_PERIOD_CYCLES = CTRL_PERIOD_NS / CLK_PERIOD_NS;
  localparam int ITIME_UNIT_NS = 100000000; // 0.1 s
  localparam int DTIME_UNIT_NS = 10000000; // 0.01 s
  localparam int FILT_UNIT_NS = 100000000; // 0.1 s
  localparam int ITIME_SCALE = ITIME_UNIT_NS / CTRL_PERIOD_NS;
  localparam int DTIME_SCALE = DTIME_UNIT_NS / CTRL_PERIOD_NS;
  localparam int FILT_SCALE = FILT_UNIT_NS / CTRL_PERIOD_NS;

endpackage : loop_ctrl_pkg

// ---- rtl/loop_ctrl.sv ----
// ============================================================
// closed loop controller with feedback filter, limiters, alarm
// ============================================================
// holds the whole controller, its register file and its checks
// assumes command, feedback and limiter inputs synchronous to clock
`timescale 1ns/1ps

// Notes on behaviour
// RULE1: mode 0 off, 1 normal, 2 inverse, 3 dancer control.
// RULE2: proportional gain 0.000 to 30.000 multiplies the deviation.
// RULE3: proportional term is deviation times gain.
// RULE4: integral time 0.0 to 3600.0 seconds.
// RULE5: integral time zero removes the integral term entirely.
// RULE6: integrator accumulates deviation, slower with longer integral time.
// RULE7: derivative time 0.00 to 600.00 seconds.
// RULE8: derivative time zero removes the derivative term entirely.
// RULE9: derivative term follows deviation rate of change times derivative time.
// RULE10: feedback is low-pass filtered, time constant 0.0 to 900.0 s.
// RULE11: integrator freezes while deviation lies outside the anti-windup band.
// RULE12: anti-windup band 0.0 to 200 percent.
// RULE13: alarm codes 0-3 absolute, 4-7 deviation; plain, hold, latch, both.
// RULE14: absolute alarm when feedback below lower or above upper level.
// RULE15: deviation alarm when feedback outside command minus lower, plus upper.
// RULE16: hold keeps alarm off until quantity leaves then re-enters range.
// RULE17: latch keeps alarm on until keypad or reset input clears it.
// RULE18: alarm levels are percentages of feedback full scale.
// RULE19: alarm reaches the digital output only with function code 42.
// RULE20: output clamped to upper percent; 999 uses high frequency limiter.
// RULE21: output clamped to lower percent; 999 uses low frequency limiter.
// RULE22: with loop off the reference passes through without limiters.
// RULE23: each control period sum enabled terms, then apply limiters.
module loop_ctrl #(
  parameter int CTRL_CYCLES = loop_ctrl_pkg::CTRL_PERIOD_CYCLES
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // register port
  input wire logic [4:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // loop quantities, 0.01 % units; command, feedback and reference signed
  input wire logic signed [15:0] i_command_value,
  input wire logic signed [15:0] i_feedback_value,
  input wire logic signed [15:0] i_ref_value,
  input wire logic [15:0] i_freq_limiter_high,
  input wire logic [15:0] i_freq_limiter_low,
  input wire logic i_alarm_reset,
  // results
  output logic signed [31:0] o_manipulated_value,
  output logic o_loop_active,
  output logic o_loop_alarm_out
);

  // ==========================================================
  // helpers
  // ==========================================================
  // magnitude of a signed word
  function automatic logic signed [47:0] mag(
    input logic signed [47:0] v
  );
    mag = (v < 0) ? -v : v;
  endfunction : mag

  // unsigned 16-bit setting widened to signed 48-bit
  function automatic logic signed [47:0] uext(input logic [15:0] v);
    uext = $signed({32'h0, v});
  endfunction : uext

  // ==========================================================
  // registers written by software
  // ==========================================================
  logic [1:0] mode_reg;
  logic [15:0] gain_reg, itime_reg, dtime_reg, filt_reg, awb_reg;
  logic [2:0] alm_type_reg;
  logic [15:0] alm_up_reg, alm_lo_reg, out_up_reg, out_lo_reg;
  logic [15:0] dout_func_reg;
  logic clr_req;

  // register writes, one word per index
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      mode_reg <= loop_ctrl_pkg::MODE_OFF;
      gain_reg <= loop_ctrl_pkg::RST_GAIN;
      itime_reg <= loop_ctrl_pkg::RST_ZERO;
      dtime_reg <= loop_ctrl_pkg::RST_ZERO;
      filt_reg <= loop_ctrl_pkg::RST_ZERO;
      awb_reg <= loop_ctrl_pkg::RST_ZERO;
      alm_type_reg <= 3'h0;
      alm_up_reg <= loop_ctrl_pkg::RST_ZERO;
      alm_lo_reg <= loop_ctrl_pkg::RST_ZERO;
      out_up_reg <= loop_ctrl_pkg::RST_OUT_UP;
      out_lo_reg <= loop_ctrl_pkg::RST_OUT_LO;
      dout_func_reg <= loop_ctrl_pkg::RST_ZERO;
    end else if (i_wr) begin
      case (i_addr)
        loop_ctrl_pkg::IDX_MODE: mode_reg <= i_wdata[1:0]; // see RULE1
        loop_ctrl_pkg::IDX_GAIN: gain_reg <= i_wdata; // see RULE2
        loop_ctrl_pkg::IDX_ITIME: itime_reg <= i_wdata; // see RULE4
        loop_ctrl_pkg::IDX_DTIME: dtime_reg <= i_wdata; // see RULE7
        loop_ctrl_pkg::IDX_FILT: filt_reg <= i_wdata; // see RULE10
        loop_ctrl_pkg::IDX_AWB: awb_reg <= i_wdata; // see RULE12
        loop_ctrl_pkg::IDX_ALM_TYPE: alm_type_reg <= i_wdata[2:0];
        loop_ctrl_pkg::IDX_ALM_UP: alm_up_reg <= i_wdata; // see RULE18
        loop_ctrl_pkg::IDX_ALM_LO: alm_lo_reg <= i_wdata; // see RULE18
        loop_ctrl_pkg::IDX_OUT_UP: out_up_reg <= i_wdata;
        loop_ctrl_pkg::IDX_OUT_LO: out_lo_reg <= i_wdata;
        loop_ctrl_pkg::IDX_DOUT_FUNC: dout_func_reg <= i_wdata;
        default: ;
      endcase
    end
  end

  // latch release: reset input or a write of the clear bit
  assign clr_req = i_alarm_reset | (i_wr && i_addr == loop_ctrl_pkg::IDX_CTRL
    && i_wdata[loop_ctrl_pkg::CTRL_CLR_BIT]);

  // ==========================================================
  // control period tick
  // ==========================================================
  logic [31:0] tick_cnt_reg;
  logic tick;
  assign tick = (tick_cnt_reg == 32'(CTRL_CYCLES - 1));

  // free running period counter
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || tick) begin
      tick_cnt_reg <= 32'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end

  // ==========================================================
  // feedback filter
  // ==========================================================
  logic signed [47:0] filt_acc_reg, fb_fix, fb_filt, filt_step;
  assign fb_fix = 48'(i_feedback_value) <<< loop_ctrl_pkg::FRAC_BITS;
  assign fb_filt = filt_acc_reg >>> loop_ctrl_pkg::FRAC_BITS;
  assign filt_step = (filt_reg == 16'h0) ? 48'sh0 :
    (fb_fix - filt_acc_reg) /
    (uext(filt_reg) * 48'(loop_ctrl_pkg::FILT_SCALE));

  // first order lag, updated each period; zero time passes through
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      filt_acc_reg <= 48'sh0;
    end else if (tick) begin
      if (filt_reg == 16'h0) begin
        filt_acc_reg <= fb_fix; // see RULE10
      end else begin
        filt_acc_reg <= filt_acc_reg + filt_step; // see RULE10
      end
    end
  end

  // ==========================================================
  // deviation and loop terms
  // ==========================================================
  logic signed [47:0] dev, p_term, p_prev_reg, d_term, i_term;
  logic signed [47:0] integ_acc_reg, integ_step, mv_sum;
  logic signed [47:0] lim_hi, lim_lo, mv_clamped;
  logic freeze;

  // inverse mode turns the deviation round
  assign dev = (mode_reg == loop_ctrl_pkg::MODE_INVERSE) ?
    fb_filt - 48'(i_command_value) :
    48'(i_command_value) - fb_filt; // see RULE1
  assign p_term = (dev * uext(gain_reg)) /
    48'(loop_ctrl_pkg::GAIN_DIV); // see RULE3
  assign freeze = (awb_reg != 16'h0) && (mag(dev) >
    uext(awb_reg) * 48'(loop_ctrl_pkg::AWB_TO_CENTI)); // see RULE11
  assign integ_step = (itime_reg == 16'h0) ? 48'sh0 :
    (p_term <<< loop_ctrl_pkg::FRAC_BITS) /
    (uext(itime_reg) * 48'(loop_ctrl_pkg::ITIME_SCALE)); // see RULE6
  assign i_term = integ_acc_reg >>> loop_ctrl_pkg::FRAC_BITS;
  assign d_term = (dtime_reg == 16'h0) ? 48'sh0 : // see RULE8
    (p_term - p_prev_reg) * uext(dtime_reg) *
    48'(loop_ctrl_pkg::DTIME_SCALE); // see RULE9
  assign mv_sum = p_term + i_term + d_term; // see RULE23

  // integrator, cleared when the integral time is zero
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || itime_reg == 16'h0
        || mode_reg == loop_ctrl_pkg::MODE_OFF) begin
      integ_acc_reg <= 48'sh0; // see RULE5
    end else if (tick && !freeze) begin
      integ_acc_reg <= integ_acc_reg + integ_step; // see RULE6
    end
  end

  // previous proportional value for the rate term
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      p_prev_reg <= 48'sh0;
    end else if (tick) begin
      p_prev_reg <= p_term;
    end
  end

  // ==========================================================
  // output limiters and manipulated value
  // ==========================================================
  assign lim_hi = (out_up_reg == loop_ctrl_pkg::CLAMP_USE_LIMITER) ?
    uext(i_freq_limiter_high) : // see RULE20
    uext(out_up_reg) * 48'(loop_ctrl_pkg::PCT_TO_CENTI);
  assign lim_lo = (out_lo_reg == loop_ctrl_pkg::CLAMP_USE_LIMITER) ?
    uext(i_freq_limiter_low) : // see RULE21
    uext(out_lo_reg) * 48'(loop_ctrl_pkg::PCT_TO_CENTI);
  // upper limit tested first, and a crossed lower limit falls back to it, so upper wins
  assign mv_clamped = (mv_sum > lim_hi) ? lim_hi : // see RULE20
    (mv_sum < lim_lo) ? ((lim_lo > lim_hi) ? lim_hi : lim_lo) :
    mv_sum; // see RULE21

  // new value once per period; reference passes when loop is off
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_manipulated_value <= 32'sh0;
      o_loop_active <= 1'b0;
    end else if (tick) begin
      o_loop_active <= (mode_reg != loop_ctrl_pkg::MODE_OFF);
      if (mode_reg == loop_ctrl_pkg::MODE_OFF) begin
        o_manipulated_value <= 32'(i_ref_value); // see RULE22
      end else begin
        o_manipulated_value <= mv_clamped[31:0]; // see RULE23
      end
    end
  end

  // ==========================================================
  // loop alarm
  // ==========================================================
  logic signed [47:0] alm_hi, alm_lo, fb_raw;
  logic in_range, armed_reg, alarm_reg;
  assign fb_raw = 48'(i_feedback_value);
  assign alm_hi = alm_type_reg[loop_ctrl_pkg::ALM_DEV_BIT] ?
    48'(i_command_value) + uext(alm_up_reg) : uext(alm_up_reg);
  assign alm_lo = alm_type_reg[loop_ctrl_pkg::ALM_DEV_BIT] ?
    48'(i_command_value) - uext(alm_lo_reg) : uext(alm_lo_reg);
  assign in_range = (fb_raw < alm_lo) || (fb_raw > alm_hi); // see RULE13

  // hold arming: set once the quantity has been outside the range
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      armed_reg <= 1'b0;
    end else if (!in_range) begin
      armed_reg <= 1'b1; // see RULE16
    end
  end

  // alarm state; a new alarm wins over a clear in the same cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      alarm_reg <= 1'b0;
    end else if (in_range && (armed_reg ||
        !alm_type_reg[loop_ctrl_pkg::ALM_HOLD_BIT])) begin
      alarm_reg <= 1'b1; // see RULE14 see RULE15 see RULE16
    end else if (!alm_type_reg[loop_ctrl_pkg::ALM_LATCH_BIT]
        || clr_req) begin
      alarm_reg <= 1'b0; // see RULE17
    end
  end

  // digital output only carries the alarm with its function code
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_loop_alarm_out <= 1'b0;
    end else begin
      o_loop_alarm_out <= alarm_reg &&
        (dout_func_reg == loop_ctrl_pkg::DOUT_FUNC_ALARM); // see RULE19
    end
  end

  // ==========================================================
  // register reads, data one cycle after the strobe
  // ==========================================================
  logic [15:0] status;
  assign status = {12'h0, o_loop_active, freeze, armed_reg, alarm_reg};

  // read mux; unmapped indices read zero
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_rdata <= 16'h0;
    end else if (i_rd) begin
      case (i_addr)
        loop_ctrl_pkg::IDX_MODE: o_rdata <= {14'h0, mode_reg};
        loop_ctrl_pkg::IDX_GAIN: o_rdata <= gain_reg;
        loop_ctrl_pkg::IDX_ITIME: o_rdata <= itime_reg;
        loop_ctrl_pkg::IDX_DTIME: o_rdata <= dtime_reg;
        loop_ctrl_pkg::IDX_FILT: o_rdata <= filt_reg;
        loop_ctrl_pkg::IDX_AWB: o_rdata <= awb_reg;
        loop_ctrl_pkg::IDX_ALM_TYPE: o_rdata <= {13'h0, alm_type_reg};
        loop_ctrl_pkg::IDX_ALM_UP: o_rdata <= alm_up_reg;
        loop_ctrl_pkg::IDX_ALM_LO: o_rdata <= alm_lo_reg;
        loop_ctrl_pkg::IDX_OUT_UP: o_rdata <= out_up_reg;
        loop_ctrl_pkg::IDX_OUT_LO: o_rdata <= out_lo_reg;
        loop_ctrl_pkg::IDX_DOUT_FUNC: o_rdata <= dout_func_reg;
        loop_ctrl_pkg::IDX_STATUS: o_rdata <= status;
        loop_ctrl_pkg::IDX_MV: o_rdata <= o_manipulated_value[15:0];
        loop_ctrl_pkg::IDX_FB_FILT: o_rdata <= fb_filt[15:0];
        default: o_rdata <= 16'h0;
      endcase
    end else begin
      o_rdata <= 16'h0;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  property p_off_passes_ref;
    tick && mode_reg == loop_ctrl_pkg::MODE_OFF |=>
      o_manipulated_value == 32'($past(i_ref_value)) && !o_loop_active;
  endproperty
  a_off_passes_ref: assert property (p_off_passes_ref) // see RULE22
    else $error("reference not passed through with loop off");

  property p_upper_clamp;
    tick && mode_reg != loop_ctrl_pkg::MODE_OFF |=>
      48'(o_manipulated_value) <= $past(lim_hi);
  endproperty
  a_upper_clamp: assert property (p_upper_clamp) // see RULE20
    else $error("output above upper limit");

  property p_lower_clamp;
    tick && mode_reg != loop_ctrl_pkg::MODE_OFF && lim_lo <= lim_hi |=>
      48'(o_manipulated_value) >= $past(lim_lo);
  endproperty
  a_lower_clamp: assert property (p_lower_clamp) // see RULE21
    else $error("output below lower limit");

  // a zero integral time or loop off clears the integrator on purpose
  property p_freeze_holds;
    tick && freeze && itime_reg != 16'h0 &&
      mode_reg != loop_ctrl_pkg::MODE_OFF |=> $stable(integ_acc_reg);
  endproperty
  a_freeze_holds: assert property (p_freeze_holds) // see RULE11
    else $error("integrator moved while outside band");

  property p_no_integral;
    itime_reg == 16'h0 |=> integ_acc_reg == 48'sh0;
  endproperty
  a_no_integral: assert property (p_no_integral) // see RULE5
    else $error("integral kept with zero integral time");

  property p_abs_alarm;
    alm_type_reg == 3'h0 && (fb_raw > uext(alm_up_reg)) |=> alarm_reg;
  endproperty
  a_abs_alarm: assert property (p_abs_alarm) // see RULE14
    else $error("absolute alarm missed");

  property p_dev_alarm;
    alm_type_reg == 3'h4 && (fb_raw < 48'(i_command_value) -
      uext(alm_lo_reg)) |=> alarm_reg;
  endproperty
  a_dev_alarm: assert property (p_dev_alarm) // see RULE15
    else $error("deviation alarm missed");

  property p_hold_unarmed;
    alm_type_reg[loop_ctrl_pkg::ALM_HOLD_BIT] && !armed_reg |=>
      !alarm_reg || $past(alarm_reg);
  endproperty
  a_hold_unarmed: assert property (p_hold_unarmed) // see RULE16
    else $error("alarm raised before arming under hold");

  property p_latch_keeps;
    alarm_reg && alm_type_reg[loop_ctrl_pkg::ALM_LATCH_BIT] && !clr_req
      |=> alarm_reg;
  endproperty
  a_latch_keeps: assert property (p_latch_keeps) // see RULE17
    else $error("latched alarm dropped without reset");

  property p_dout_gate;
    dout_func_reg != loop_ctrl_pkg::DOUT_FUNC_ALARM |=> !o_loop_alarm_out;
  endproperty
  a_dout_gate: assert property (p_dout_gate) // see RULE19
    else $error("alarm on output without function code");

  c_alarm_out: cover property (alarm_reg ##1 o_loop_alarm_out);
  c_freeze: cover property (tick && freeze);
  c_clamp_hit: cover property (tick && mode_reg != 2'h0 && mv_sum > lim_hi);
  c_latch_clear: cover property (alarm_reg && clr_req && !in_range
    ##1 !alarm_reg);

endmodule : loop_ctrl

// ---- testbench/loop_partner.sv ----
// ============================================================
// partner model: feedback sensor and frequency limiter source
// ============================================================
// assumes the bench sets the level that the sensor should report
`timescale 1ns/1ps
module loop_partner #(
  parameter logic [15:0] LIM_HI = 16'h2710,
  parameter logic [15:0] LIM_LO = 16'h0000
) (
  // clock
  input wire logic i_clk_sys,
  // sensed level and frequency path settings
  input wire logic signed [15:0] i_target,
  output logic signed [15:0] o_feedback_value,
  output logic [15:0] o_freq_limiter_high,
  output logic [15:0] o_freq_limiter_low
);
  // sensor reports one clock late, like a sampled converter
  always_ff @(posedge i_clk_sys) begin
    o_feedback_value <= i_target;
  end
  // limiter settings held by the frequency path
  assign o_freq_limiter_high = LIM_HI;
  assign o_freq_limiter_low = LIM_LO;
endmodule : loop_partner

// ---- testbench/test_loop_ctrl.sv ----
// ============================================================
// self-checking bench for the closed loop controller
// ============================================================
// assumes a short control period and a sensor partner model
`timescale 1ns/1ps
module test_loop_ctrl;
  localparam int CYC = 8;
  logic clk_sys, rst, wr, rd, alarm_reset, active, alarm;
  logic [4:0] addr;
  logic [15:0] wdata, rdata, lim_hi, lim_lo, d;
  logic signed [15:0] cmd, target, fb, ref_val;
  logic signed [31:0] mv, m0, peak;
  int fail_count, compares, cycles;

  // clock and timeout guard
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  loop_ctrl #(.CTRL_CYCLES(CYC)) loop_ctrl_i (.i_clk_sys(clk_sys),
    .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_command_value(cmd), .i_feedback_value(fb),
    .i_ref_value(ref_val), .i_freq_limiter_high(lim_hi),
    .i_freq_limiter_low(lim_lo), .i_alarm_reset(alarm_reset),
    .o_manipulated_value(mv), .o_loop_active(active),
    .o_loop_alarm_out(alarm));
  loop_partner loop_partner_i (.i_clk_sys(clk_sys), .i_target(target),
    .o_feedback_value(fb), .o_freq_limiter_high(lim_hi),
    .o_freq_limiter_low(lim_lo));

  // compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wr_reg
  // one-cycle read strobe, data taken in the following cycle
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg
  task automatic settle();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : settle
  task automatic ticks(input int n);
    repeat (n * CYC) @(posedge clk_sys);
    #1;
  endtask : ticks
  task automatic wrap_up();
    if (fail_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // main sequence
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    {addr, wdata, wr, rd, alarm_reset} = '0;
    cmd = 16'sh0000;
    target = 16'sh0064;
    ref_val = 16'sh2ee0;
    fail_count = 0;
    compares = 0;
    cycles = 0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    // reset values and an unmapped index
    rd_reg(loop_ctrl_pkg::IDX_GAIN, d);
    chk(d, 16'h0064);
    rd_reg(loop_ctrl_pkg::IDX_OUT_LO, d);
    chk(d, 16'h03e7);
    wr_reg(5'h13, 16'h00ff);
    rd_reg(5'h13, d);
    chk(d, 16'h0000);
    // hold: in alarm range since power on, so the unarmed alarm drops; once armed, a new excursion turns the output on
    wr_reg(loop_ctrl_pkg::IDX_DOUT_FUNC, loop_ctrl_pkg::DOUT_FUNC_ALARM);
    wr_reg(loop_ctrl_pkg::IDX_ALM_TYPE, 16'h0001);
    settle();
    chk(alarm, 1'b0);
    wr_reg(loop_ctrl_pkg::IDX_ALM_UP, 16'h0fa0);
    settle();
    target <= 16'sh1388;
    settle();
    chk(alarm, 1'b1);
    // loop off: reference passes without limiters
    chk(mv, 32'sh00002ee0);
    chk(active, 1'b0);
    // every alarm code: set, leave range, then clear
    for (int t = 0; t < 8; t++) begin
      wr_reg(loop_ctrl_pkg::IDX_ALM_TYPE, 16'(t));
      target <= 16'sh1388;
      settle();
      chk(alarm, 1'b1);
      target <= 16'sh07d0;
      settle();
      chk(alarm, t[1]);
      if (t < 4) begin
        alarm_reset <= 1'b1;
        settle();
        alarm_reset <= 1'b0;
      end else begin
        wr_reg(loop_ctrl_pkg::IDX_CTRL, 16'h0001);
      end
      settle();
      chk(alarm, 1'b0);
    end
    // absolute versus deviation window, levels 10 %
    cmd <= 16'sh0bb8;
    wr_reg(loop_ctrl_pkg::IDX_ALM_UP, 16'h03e8);
    wr_reg(loop_ctrl_pkg::IDX_ALM_LO, 16'h03e8);
    target <= 16'sh0dac;
    wr_reg(loop_ctrl_pkg::IDX_ALM_TYPE, 16'h0000);
    settle();
    chk(alarm, 1'b1);
    wr_reg(loop_ctrl_pkg::IDX_ALM_TYPE, 16'h0004);
    settle();
    chk(alarm, 1'b0);
    target <= 16'sh05dc;
    settle();
    chk(alarm, 1'b1);
    wr_reg(loop_ctrl_pkg::IDX_DOUT_FUNC, 16'h0029);
    settle();
    chk(alarm, 1'b0);
    // proportional only, gain 1.000, deviation 20 %
    target <= 16'sh03e8;
    wr_reg(loop_ctrl_pkg::IDX_GAIN, 16'h03e8);
    for (int m = 1; m < 4; m++) begin
      wr_reg(loop_ctrl_pkg::IDX_MODE, 16'(m));
      ticks(3);
      chk(mv, (m == 2) ? 32'sh0 : 32'sh000007d0);
      chk(active, 1'b1);
    end
    rd_reg(loop_ctrl_pkg::IDX_FB_FILT, d);
    chk(d, 16'h03e8);
    wr_reg(loop_ctrl_pkg::IDX_OUT_LO, 16'h0019);
    ticks(2);
    chk(mv, 32'sh000009c4);
    wr_reg(loop_ctrl_pkg::IDX_OUT_LO, 16'h03e7);
    wr_reg(loop_ctrl_pkg::IDX_MODE, 16'h0001);
    wr_reg(loop_ctrl_pkg::IDX_OUT_UP, 16'h000f);
    ticks(2);
    chk(mv, 32'sh000005dc);
    wr_reg(loop_ctrl_pkg::IDX_OUT_UP, 16'h03e7);
    // derivative kicks on a command step, then fades
    wr_reg(loop_ctrl_pkg::IDX_DTIME, 16'h0001);
    ticks(2);
    cmd <= 16'sh0c1c;
    peak = 32'sh0;
    repeat (3 * CYC) begin
      @(posedge clk_sys);
      #1;
      if (mv > peak) peak = mv;
    end
    chk(32'(peak > 32'sh00000834), 32'h1);
    ticks(2);
    chk(mv, 32'sh00000834);
    wr_reg(loop_ctrl_pkg::IDX_DTIME, 16'h0000);
    cmd <= 16'sh0bb8;
    ticks(2);
    chk(mv, 32'sh000007d0);
    // integral rises 20 per tick, frozen outside the band
    wr_reg(loop_ctrl_pkg::IDX_ITIME, 16'h0001);
    ticks(2);
    m0 = mv;
    ticks(4);
    chk(mv - m0, 32'sh50);
    wr_reg(loop_ctrl_pkg::IDX_AWB, 16'h0001);
    ticks(1);
    m0 = mv;
    ticks(4);
    chk(mv - m0, 32'sh0);
    rd_reg(loop_ctrl_pkg::IDX_STATUS, d);
    chk(d[loop_ctrl_pkg::ST_FREEZE_BIT], 1'b1);
    wr_reg(loop_ctrl_pkg::IDX_ITIME, 16'h0000);
    ticks(2);
    chk(mv, 32'sh000007d0);
    // filtered feedback moves only part of the way toward a step
    wr_reg(loop_ctrl_pkg::IDX_FILT, 16'h0001);
    target <= 16'sh07d0;
    ticks(2);
    rd_reg(loop_ctrl_pkg::IDX_FB_FILT, d);
    chk(32'(d > 16'h03e8 && d < 16'h07d0), 32'h1);
    wrap_up();
  end
endmodule : test_loop_ctrl
